// *** aal1_mapper_pkg.sv ***
// Purpose: Shared constants and carrier types for the AAL-1 structured cell mapper
// Assumes: 250 MHz core clock, one TDM slot per tdmValid strobe
// Notes: Header words and control offsets are local choices
`default_nettype none
package aal1_mapper_pkg;
    // ****************************************
    // Frame and cell geometry
    // ****************************************
    localparam int SLOTS_PER_FRAME = 3072;
    localparam int USABLE_MAX = 2048;
    localparam int DEDICATED_CHANS = 2016;
    localparam int MSG_CHANS = 32;
    localparam int NUM_ENGINES = 2;
    localparam int PAYLOAD_BYTES = 48;
    localparam int SINGLE_SAMPLES = 47;
    localparam int CELL_WORDS = 27;
    localparam int HDR_WORDS = 3;
    localparam logic [6:0] PTR_NONE = 7'h7F;
    // ****************************************
    // Cell interface timing
    // ****************************************
    localparam int CORE_CLK_MHZ = 250;
    localparam int CELL_IF_MAX_MHZ = 50;
    localparam int CELL_IF_DIV = (CORE_CLK_MHZ + CELL_IF_MAX_MHZ - 1) / CELL_IF_MAX_MHZ;
    localparam int CELL_IF_TICK = 2;
    localparam int FIFO_DEPTH = 8;
    // ****************************************
    // Configuration port map and cell header words
    // ****************************************
    localparam logic [11:0] CFG_MODE_BASE = 12'hC00;
    localparam logic [11:0] CFG_MISC = 12'hC02;
    localparam logic [11:0] CFG_STATUS = 12'hC03;
    localparam int MISC_LOOP_BIT = 0;
    localparam int MISC_MSG_BIT = 1;
    localparam logic [31:0] CELL_HDR0 = 32'h0000_0100;
    localparam logic [31:0] CELL_HDR1 = 32'h0000_0110;

    typedef enum logic [1:0] {
        MODE_SDT = 2'h0,
        MODE_SINGLE = 2'h1,
        MODE_SUDT = 2'h2,
        MODE_AAL0 = 2'h3
    } mode_e;

    typedef struct packed {
        logic frameStart;
        logic avail;
        logic [7:0] data;
    } tdmSlot_s;

    typedef struct packed {
        logic soc;
        logic [15:0] data;
    } cellWord_s;
endpackage
`default_nettype wire

// *** cell_word_fifo.sv ***
// Purpose: Small valid/ready FIFO between cell builder and cell interface
// Assumes: DEPTH is a power of two
// Notes: Full and empty come from pointers with a wrap bit
`timescale 1ns/100ps
`default_nettype none
module cell_word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;
    logic push;
    logic pop;

    assign inReady = !((wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]));
    assign outValid = (wrPtr_reg != rdPtr_reg);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr_reg[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end
endmodule // cell_word_fifo
`default_nettype wire

// *** aal1_structured_cell_mapper.sv ***
// Purpose: Map strobed TDM slots into AAL-1 cells and send them over a 16-bit cell bus
// Assumes: Slots arrive synchronous to core_clk; frameStart marks slot 0
// Notes: Two engines share one slot stream; each owns one circuit and one cell buffer
`timescale 1ns/100ps
`default_nettype none
module aal1_structured_cell_mapper
    import aal1_mapper_pkg::*;
#(
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tdmValid,
    input wire tdmSlot_s tdmIn,
    output logic [7:0] tdmLoopData,
    input wire logic cfgWr,
    input wire logic cfgRd,
    input wire logic [11:0] cfgAddr,
    input wire logic [7:0] cfgWrData,
    output logic [7:0] cfgRdData,
    output logic cfgBusy,
    output logic cellClk,
    output logic [15:0] cellData,
    output logic cellSoc,
    output logic cellEnb_n,
    input wire logic cellClav
);
    typedef enum logic [1:0] {SER_IDLE = 2'h1, SER_SEND = 2'h2} serState_e;

    function automatic logic [7:0] seqByte(input logic csi, input logic [2:0] sc);
        logic [2:0] rem;
        logic [3:0] d;
        logic fb;
        rem = 3'h0;
        d = {csi, sc};
        for (int i = 3; i >= 0; i--) begin
            fb = d[i] ^ rem[2];
            rem = {rem[1], rem[0] ^ fb, fb};
        end
        return {d, rem, ^{d, rem}};
    endfunction

    function automatic logic [5:0] hdrLen(input mode_e m, input logic ptr);
        return (m == MODE_AAL0) ? 6'h0 : (ptr ? 6'h2 : 6'h1);
    endfunction

    // ****************************************
    // Configuration store and port
    // ****************************************
    logic [1:0] chanEn [0:SLOTS_PER_FRAME-1];
    mode_e mode_reg [NUM_ENGINES];
    logic loopEn_reg;
    logic msgReassign_reg;
    logic [11:0] clrIdx_reg;
    logic [NUM_ENGINES-1:0] full_reg;
    logic [2:0] seq_reg [NUM_ENGINES];

    // Enable map has no reset; it is swept to zero after reset so no slot maps early
    always_ff @(posedge core_clk) begin
        if (cfgBusy) begin
            chanEn[clrIdx_reg] <= 2'h0;
        end else if (cfgWr && cfgAddr < 12'(SLOTS_PER_FRAME)) begin
            chanEn[cfgAddr] <= cfgWrData[1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfgBusy <= 1'b1;
            clrIdx_reg <= 12'h000;
        end else if (cfgBusy) begin
            clrIdx_reg <= 12'(clrIdx_reg + 12'h001);
            cfgBusy <= (clrIdx_reg != 12'(SLOTS_PER_FRAME - 1));
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_reg[0] <= MODE_SDT;
            mode_reg[1] <= MODE_SDT;
            loopEn_reg <= 1'b0;
            msgReassign_reg <= 1'b0;
            cfgRdData <= 8'h00;
        end else begin
            if (cfgWr && !cfgBusy) begin
                if (cfgAddr == CFG_MODE_BASE || cfgAddr == 12'(CFG_MODE_BASE + 12'h001)) begin
                    mode_reg[cfgAddr[0]] <= mode_e'(cfgWrData[1:0]);
                end else if (cfgAddr == CFG_MISC) begin
                    loopEn_reg <= cfgWrData[MISC_LOOP_BIT];
                    msgReassign_reg <= cfgWrData[MISC_MSG_BIT];
                end
            end
            if (cfgRd) begin
                if (cfgAddr < 12'(SLOTS_PER_FRAME)) begin
                    cfgRdData <= {6'h00, chanEn[cfgAddr]};
                end else if (cfgAddr == CFG_MODE_BASE || cfgAddr == 12'(CFG_MODE_BASE + 12'h001)) begin
                    cfgRdData <= {6'h00, mode_reg[cfgAddr[0]]};
                end else if (cfgAddr == CFG_MISC) begin
                    cfgRdData <= {6'h00, msgReassign_reg, loopEn_reg};
                end else if (cfgAddr == CFG_STATUS) begin
                    cfgRdData <= {seq_reg[1], seq_reg[0], full_reg};
                end else begin
                    cfgRdData <= 8'h00;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tdmLoopData <= 8'h00;
        end else if (tdmValid) begin
            tdmLoopData <= loopEn_reg ? tdmIn.data : 8'h00;
        end
    end

    // ****************************************
    // Slot counting and channel selection
    // ****************************************
    logic [11:0] slot_reg;
    logic [11:0] avail_reg;
    logic [11:0] curSlot;
    logic [11:0] curAvail;
    logic mappable;
    logic [NUM_ENGINES-1:0] useE;

    assign curSlot = tdmIn.frameStart ? 12'h000 : slot_reg;
    assign curAvail = tdmIn.frameStart ? 12'h000 : avail_reg;
    // Top 32 usable channels may be handed to messaging instead
    assign mappable = tdmIn.avail && !cfgBusy && (curAvail < (msgReassign_reg ? 12'(DEDICATED_CHANS)
        : 12'(DEDICATED_CHANS + MSG_CHANS)));
    assign useE = mappable ? chanEn[curSlot] : 2'h0;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slot_reg <= 12'h000;
            avail_reg <= 12'h000;
        end else if (tdmValid) begin
            slot_reg <= (curSlot == 12'(SLOTS_PER_FRAME - 1)) ? 12'h000 : 12'(curSlot + 12'h001);
            avail_reg <= tdmIn.avail ? 12'(curAvail + 12'h001) : curAvail;
        end
    end

    // ****************************************
    // Adaptation engines
    // ****************************************
    logic [7:0] cellBuf [NUM_ENGINES][PAYLOAD_BYTES];
    logic [5:0] wrIdx_reg [NUM_ENGINES];
    logic [NUM_ENGINES-1:0] seen_reg;
    logic [NUM_ENGINES-1:0] ptrSet_reg;
    logic [NUM_ENGINES-1:0] cellHasPtr_reg;
    logic [NUM_ENGINES-1:0] drainDone;
    logic [NUM_ENGINES-1:0] ptrCell;
    logic [5:0] wrPos [NUM_ENGINES];
    logic [5:0] nextPos [NUM_ENGINES];

    always_comb begin
        for (int e = 0; e < NUM_ENGINES; e++) begin
            ptrCell[e] = (wrIdx_reg[e] == 6'h0) ? (mode_reg[e] == MODE_SDT && seq_reg[e] == 3'h0)
                : cellHasPtr_reg[e];
            wrPos[e] = (wrIdx_reg[e] == 6'h0) ? hdrLen(mode_reg[e], ptrCell[e]) : wrIdx_reg[e];
            nextPos[e] = 6'(wrPos[e] + 6'h1);
        end
    end

    // A byte for a busy buffer is lost; the drain runs far faster than any circuit fills
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int e = 0; e < NUM_ENGINES; e++) begin
                wrIdx_reg[e] <= 6'h0;
                seq_reg[e] <= 3'h0;
            end
            full_reg <= '0;
            seen_reg <= '0;
            ptrSet_reg <= '0;
            cellHasPtr_reg <= '0;
        end else begin
            for (int e = 0; e < NUM_ENGINES; e++) begin
                if (drainDone[e]) begin
                    full_reg[e] <= 1'b0;
                end
                if (tdmValid) begin
                    seen_reg[e] <= tdmIn.frameStart ? useE[e] : (seen_reg[e] | useE[e]);
                end
                if (tdmValid && useE[e] && !full_reg[e]) begin
                    if (wrIdx_reg[e] == 6'h0) begin
                        if (mode_reg[e] != MODE_AAL0) begin
                            cellBuf[e][0] <= seqByte(ptrCell[e], seq_reg[e]);
                        end
                        if (ptrCell[e]) begin
                            cellBuf[e][1] <= {^PTR_NONE, PTR_NONE};
                        end
                        cellHasPtr_reg[e] <= ptrCell[e];
                        ptrSet_reg[e] <= 1'b0;
                    end
                    cellBuf[e][wrPos[e]] <= tdmIn.data;
                    // First selected slot of a frame opens a structure
                    if (ptrCell[e] && (tdmIn.frameStart || !seen_reg[e])
                        && (wrIdx_reg[e] == 6'h0 || !ptrSet_reg[e])) begin
                        cellBuf[e][1] <= {^(wrPos[e] - 6'h2), 1'b0, 6'(wrPos[e] - 6'h2)};
                        ptrSet_reg[e] <= 1'b1;
                    end
                    if (nextPos[e] == 6'(PAYLOAD_BYTES)) begin
                        full_reg[e] <= 1'b1;
                        wrIdx_reg[e] <= 6'h0;
                        seq_reg[e] <= 3'(seq_reg[e] + 3'h1);
                    end else begin
                        wrIdx_reg[e] <= nextPos[e];
                    end
                end
            end
        end
    end

    // ****************************************
    // Cell serialiser into the FIFO
    // ****************************************
    serState_e serState_reg;
    logic serSel_reg;
    logic rr_reg;
    logic [4:0] wordIdx_reg;
    logic [5:0] payIdx;
    logic [31:0] hdr;
    cellWord_s fifoIn;
    cellWord_s fifoOut;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic push;

    assign hdr = serSel_reg ? CELL_HDR1 : CELL_HDR0;
    assign payIdx = 6'({wordIdx_reg, 1'b0} - 6'(2 * HDR_WORDS));
    assign push = (serState_reg == SER_SEND) && fifoInReady;
    assign drainDone = (push && wordIdx_reg == 5'(CELL_WORDS - 1)) ? (2'h1 << serSel_reg) : 2'h0;

    always_comb begin
        fifoIn.soc = (wordIdx_reg == 5'h0);
        case (wordIdx_reg)
            5'h00: fifoIn.data = hdr[31:16];
            5'h01: fifoIn.data = hdr[15:0];
            5'h02: fifoIn.data = 16'h0000;
            default: fifoIn.data = {cellBuf[serSel_reg][payIdx], cellBuf[serSel_reg][6'(payIdx + 6'h1)]};
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            serState_reg <= SER_IDLE;
            serSel_reg <= 1'b0;
            rr_reg <= 1'b0;
            wordIdx_reg <= 5'h00;
        end else begin
            case (serState_reg)
                SER_IDLE: begin
                    wordIdx_reg <= 5'h00;
                    if (full_reg[rr_reg] || full_reg[!rr_reg]) begin
                        serSel_reg <= full_reg[rr_reg] ? rr_reg : !rr_reg;
                        serState_reg <= SER_SEND;
                    end
                end
                SER_SEND: begin
                    if (push) begin
                        wordIdx_reg <= 5'(wordIdx_reg + 5'h01);
                        if (wordIdx_reg == 5'(CELL_WORDS - 1)) begin
                            serState_reg <= SER_IDLE;
                            rr_reg <= !serSel_reg;
                        end
                    end
                end
                default: serState_reg <= SER_IDLE;
            endcase
        end
    end

    cell_word_fifo #(.WIDTH($bits(cellWord_s)), .DEPTH(FIFO_WORDS)) wordFifo (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(serState_reg == SER_SEND),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOut)
    );

    // ****************************************
    // Cell bus transmit, 50 MHz from a divider
    // ****************************************
    logic [2:0] div_reg;
    logic [4:0] outCnt_reg;
    logic tick;

    assign tick = (div_reg == 3'(CELL_IF_TICK));
    // Cell start waits for cell-available; later words flow as the FIFO offers them
    assign fifoOutReady = tick && (outCnt_reg != 5'h00 || cellClav);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_reg <= 3'h0;
            cellClk <= 1'b1;
        end else begin
            div_reg <= (div_reg == 3'(CELL_IF_DIV - 1)) ? 3'h0 : 3'(div_reg + 3'h1);
            cellClk <= (div_reg == 3'(CELL_IF_DIV - 1)) || (div_reg == 3'h0);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cellData <= 16'h0000;
            cellSoc <= 1'b0;
            cellEnb_n <= 1'b1;
            outCnt_reg <= 5'h00;
        end else if (tick) begin
            cellEnb_n <= !(fifoOutValid && fifoOutReady);
            if (fifoOutValid && fifoOutReady) begin
                cellData <= fifoOut.data;
                cellSoc <= fifoOut.soc;
                outCnt_reg <= (outCnt_reg == 5'(CELL_WORDS - 1)) ? 5'h00 : 5'(outCnt_reg + 5'h01);
            end else begin
                cellSoc <= 1'b0;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence clkRise;
        !cellClk ##1 cellClk;
    endsequence
    sequence clkPeriod;
        cellClk [*2] ##1 !cellClk [*3] ##1 cellClk;
    endsequence

    slot_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
        tdmValid && curSlot == 12'(SLOTS_PER_FRAME - 1) |=> slot_reg == 12'h000)
        else $error("slot counter did not wrap");
    shared_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
        useE != 2'h0 |-> tdmIn.avail && !cfgBusy)
        else $error("engine used a slot without strobe");
    chan_limit_a: assert property (@(posedge core_clk) disable iff (rst)
        useE != 2'h0 |-> curAvail < 12'(USABLE_MAX) && !(msgReassign_reg && curAvail >= 12'(DEDICATED_CHANS)))
        else $error("channel beyond limit mapped");
    seq_step_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(full_reg[0]) |-> seq_reg[0] == 3'($past(seq_reg[0]) + 3'h1))
        else $error("sequence count did not advance");
    ptr_cell_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(full_reg[1]) |-> cellHasPtr_reg[1] == ($past(seq_reg[1]) == 3'h0 && $past(mode_reg[1]) == MODE_SDT))
        else $error("pointer placed in wrong cell");
    single_len_a: assert property (@(posedge core_clk) disable iff (rst)
        tdmValid && useE[0] && !full_reg[0] && wrIdx_reg[0] == 6'h0 && mode_reg[0] == MODE_SINGLE
        |=> wrIdx_reg[0] == 6'h2 && !cellHasPtr_reg[0])
        else $error("single channel cell layout wrong");
    bus_clock_a: assert property (@(posedge core_clk) disable iff (rst)
        clkRise |-> clkPeriod)
        else $error("cell bus clock period wrong");
    cell_start_a: assert property (@(posedge core_clk) disable iff (rst)
        fifoOutValid && fifoOutReady |-> fifoOut.soc == (outCnt_reg == 5'h00))
        else $error("cell word alignment lost");
    loop_echo_a: assert property (@(posedge core_clk) disable iff (rst)
        tdmValid && loopEn_reg |=> tdmLoopData == $past(tdmIn.data))
        else $error("loopback data wrong");
endmodule // aal1_structured_cell_mapper
`default_nettype wire

// *** utopia_phy_model.sv ***
// Purpose: Behavioural cell-bus receiver standing in for the physical-layer device
// Assumes: Words are settled at every rise of cellClk
// Notes: stall holds cell-available low so the transmit side backs up
`timescale 1ns/100ps
`default_nettype none
module utopia_phy_model
    import aal1_mapper_pkg::*;
(
    input wire logic cellClk,
    input wire logic [15:0] cellData,
    input wire logic cellSoc,
    input wire logic cellEnb_n,
    input wire logic stall,
    output logic cellClav
);
    cellWord_s rxQ[$];
    initial cellClav = 1'b0;
    // Moved on the falling edge so it is never changing at the sender's sample point
    always @(negedge cellClk) cellClav <= !stall;
    always @(posedge cellClk) begin
        if (!cellEnb_n) rxQ.push_back('{soc: cellSoc, data: cellData});
    end
endmodule // utopia_phy_model
`default_nettype wire

// *** aal1_structured_cell_mapper_tb_top.sv ***
// Purpose: Self-checking bench for the AAL-1 cell mapper
// Assumes: One engine carries traffic at a time, so cells never interleave
// Notes: Bytes carry a running count so payload order is easy to predict
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module aal1_structured_cell_mapper_tb_top
    import aal1_mapper_pkg::*;
;
    logic core_clk, rst, tdmValid, cfgWr, cfgRd, cfgBusy, cellClk, cellSoc, cellEnb_n, cellClav, stall;
    tdmSlot_s tdmIn;
    logic [7:0] tdmLoopData, cfgWrData, cfgRdData, rd;
    logic [7:0] pay [48];
    logic [11:0] cfgAddr;
    logic [15:0] cellData;
    cellWord_s w;
    int fails, testsRun, byteNo, slotPos, k;

    aal1_structured_cell_mapper #(.FIFO_WORDS(8)) dut_u (.core_clk(core_clk), .rst(rst),
        .tdmValid(tdmValid), .tdmIn(tdmIn), .tdmLoopData(tdmLoopData), .cfgWr(cfgWr), .cfgRd(cfgRd),
        .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgBusy(cfgBusy),
        .cellClk(cellClk), .cellData(cellData), .cellSoc(cellSoc), .cellEnb_n(cellEnb_n), .cellClav(cellClav));
    utopia_phy_model phy_u (.cellClk(cellClk), .cellData(cellData), .cellSoc(cellSoc),
        .cellEnb_n(cellEnb_n), .stall(stall), .cellClav(cellClav));

    // ****************************************
    // Bus helpers
    // ****************************************
    always #2 core_clk = ~core_clk;

    function automatic logic [7:0] snByte(input logic csi, input logic [2:0] sc);
        logic [6:0] r;
        r = {csi, sc, 3'h0};
        for (int i = 6; i >= 3; i--) if (r[i]) r = r ^ (7'h0B << (i - 3));
        return {csi, sc, r[2:0], ^{csi, sc, r[2:0]}};
    endfunction

    task automatic cfgWrite(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        cfgWr = 1'b1;
        cfgAddr = a;
        cfgWrData = d;
        @(negedge core_clk);
        cfgWr = 1'b0;
    endtask

    task automatic cfgRead(input logic [11:0] a);
        @(negedge core_clk);
        cfgRd = 1'b1;
        cfgAddr = a;
        @(negedge core_clk);
        cfgRd = 1'b0;
        rd = cfgRdData;
    endtask

    task automatic putSlot(input logic fs, input logic av, input logic [7:0] d);
        @(negedge core_clk);
        tdmValid = 1'b1;
        tdmIn = '{frameStart: fs, avail: av, data: d};
        @(negedge core_clk);
        tdmValid = 1'b0;
    endtask

    // Frames hold only the enabled slots; frameStart restarts the slot index
    task automatic sendBytes(input int n, input int nSlots);
        for (int i = 0; i < n; i++) begin
            putSlot(slotPos == 0, 1'b1, byteNo[7:0]);
            byteNo++;
            slotPos = (slotPos + 1 == nSlots) ? 0 : slotPos + 1;
        end
    endtask

    task automatic takeCell(input logic [31:0] hdr);
        k = 0;
        while (phy_u.rxQ.size() < CELL_WORDS && k < 2000) begin
            @(negedge core_clk);
            k++;
        end
        `CHK(k < 2000, 1'b1)
        for (int i = 0; i < CELL_WORDS; i++) begin
            w = (phy_u.rxQ.size() > 0) ? phy_u.rxQ.pop_front() : '0;
            `CHK(w.soc, i == 0)
            if (i == 0) `CHK(w.data, hdr[31:16])
            if (i == 1) `CHK(w.data, hdr[15:0])
            if (i == 2) `CHK(w.data, 16'h0000)
            if (i >= HDR_WORDS) {pay[2*i-6], pay[2*i-5]} = w.data;
        end
    endtask

    task automatic report_and_stop;
        if (fails == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic testConfig;
        cfgWrite(12'h005, 8'h01);
        k = 0;
        while (cfgBusy !== 1'b0 && k < 4000) begin
            @(negedge core_clk);
            k++;
        end
        `CHK(k < 4000, 1'b1)
        cfgRead(12'h005);
        `CHK(rd, 8'h00)
        cfgWrite(12'h005, 8'h01);
        cfgRead(12'h005);
        `CHK(rd, 8'h01)
        cfgRead(12'hD00);
        `CHK(rd, 8'h00)
        for (int m = 0; m < 4; m++) begin
            cfgWrite(CFG_MODE_BASE, 8'(m));
            cfgRead(CFG_MODE_BASE);
            `CHK(rd, 8'(m))
        end
        cfgWrite(CFG_MISC, 8'h01);
        putSlot(1'b0, 1'b0, 8'hA5);
        `CHK(tdmLoopData, 8'hA5)
        cfgWrite(CFG_MISC, 8'h00);
        putSlot(1'b0, 1'b0, 8'h5A);
        `CHK(tdmLoopData, 8'h00)
    endtask

    // One sample per frame; the bus stalls while the first cell waits
    task automatic testSingle;
        cfgWrite(CFG_MODE_BASE, {6'h00, MODE_SINGLE});
        cfgWrite(12'h000, 8'h01);
        stall = 1'b1;
        sendBytes(SINGLE_SAMPLES, 1);
        repeat (200) @(negedge core_clk);
        `CHK(phy_u.rxQ.size(), 0)
        stall = 1'b0;
        for (int c = 0; c < 2; c++) begin
            if (c == 1) sendBytes(SINGLE_SAMPLES, 1);
            takeCell(CELL_HDR0);
            `CHK(pay[0], snByte(1'b0, 3'(c)))
            for (int i = 1; i < PAYLOAD_BYTES; i++) `CHK(pay[i], 8'(47 * c + i - 1))
        end
        cfgWrite(12'h000, 8'h00);
    endtask

    // Two-slot structure on the second engine across a full pointer cycle
    task automatic testStruct;
        cfgWrite(CFG_MODE_BASE + 12'h001, {6'h00, MODE_SDT});
        cfgWrite(12'h000, 8'h02);
        cfgWrite(12'h001, 8'h02);
        byteNo = 0;
        slotPos = 0;
        for (int c = 0; c < 9; c++) begin
            sendBytes((c % 8 == 0) ? 46 : 47, 2);
            takeCell(CELL_HDR1);
            `CHK(pay[0], snByte(c % 8 == 0, 3'(c)))
            if (c == 0) `CHK(pay[1], 8'h00)
            if (c == 8) `CHK(pay[1], 8'h81)
            if (c == 3) `CHK(pay[1], 8'(46 + 47 * 2))
            if (c % 8 == 0) `CHK(pay[2], 8'(c == 0 ? 0 : 375))
        end
        cfgRead(CFG_STATUS);
        `CHK(rd, {3'h1, 3'h2, 2'h0})
    endtask

    initial begin
        {core_clk, tdmValid, cfgWr, cfgRd, stall, fails, testsRun, byteNo, slotPos} = '0;
        tdmIn = '0;
        cfgAddr = '0;
        cfgWrData = '0;
        rst = 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK({cellEnb_n, cellSoc, cfgBusy, cfgRdData}, 11'h500)
        rst = 1'b0;
        testConfig();
        testSingle();
        testStruct();
        report_and_stop();
    end

    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule // aal1_structured_cell_mapper_tb_top
`default_nettype wire
